// file: hw/cifg_bank.v
// One general register bank: four data, two address and the frame base register
`timescale 1ns/1ps
`include "cifg_regs.vh"
module cifg_bank (
    input wire core_clk_i,
    input wire rstn_i,
    input wire wr_en_i,
    input wire [`CIFG_IDX_W-1:0] wr_idx_i,
    input wire [`CIFG_DATA_W-1:0] wr_data_i,
    input wire [`CIFG_IDX_W-1:0] rd_idx_i,
    output wire [`CIFG_DATA_W-1:0] rd_data_o
);
    wire [`CIFG_DATA_W-1:0] words [0:`CIFG_BANK_REGS-1];
    genvar g;
    generate
        for (g = 0; g < `CIFG_BANK_REGS; g = g + 1) begin : g_reg
            reg [`CIFG_DATA_W-1:0] word_q;
            always @(posedge core_clk_i) begin
                if (!rstn_i) begin
                    word_q <= 16'h0000;
                end else if (wr_en_i && wr_idx_i == g) begin
                    word_q <= wr_data_i;
                end
            end
            assign words[g] = word_q;
        end
    endgenerate
    assign rd_data_o = (rd_idx_i < `CIFG_BANK_REGS) ? words[rd_idx_i] : 16'h0000;
endmodule

// file: hw/cifg_regs.vh
// Constants for the interrupt flag gating block
`ifndef CIFG_REGS_VH
`define CIFG_REGS_VH
`define CIFG_PPL_W 3
`define CIFG_PPL_RST 3'h0
`define CIFG_PPL_MASK_MIN 3'h2
`define CIFG_IEN_RST 1'b0
`define CIFG_SSEL_RST 1'b0
`define CIFG_SWI_VEC_W 6
`define CIFG_SWI_VEC_MAX 6'h1f
`define CIFG_DATA_W 16
`define CIFG_BANK_REGS 7
`define CIFG_IDX_W 3
`define CIFG_FLAG_RESERVED 1'b0
`endif

// file: hw/cifg_top.v
// Interrupt flag gating and banked general registers of the processor core
// Function
// RULE_01: Maskable interrupts are blocked while the enable flag is 0 and considered while 1.
// RULE_02: Acknowledging any interrupt clears the enable flag to 0.
// RULE_03: Stack select 0 picks the interrupt stack pointer, 1 the user stack pointer.
// RULE_04: Stack select clears on hardware acknowledge or on software interrupt vectors 0 to 31.
// RULE_05: The processor priority level is a 3-bit field with levels 0 to 7.
// RULE_06: A request is enabled only when its priority is strictly above the current level.
// RULE_07: A priority level of 2 to 7 disables all maskable requests.
// RULE_08: The reserved flag bit is written as 0 and reads as undefined (here 0).
// RULE_09: Thirteen core registers, with the seven-register bank present twice.
// RULE_10: Acceptance needs both the enable flag and the priority condition; others stay pending.
// RULE_11: Acceptance is evaluated on the clock and flags update in the acknowledge cycle.
`timescale 1ns/1ps
`include "cifg_regs.vh"
module cifg_top (
    input wire core_clk_i,
    input wire rstn_i,
    input wire irq_pend_i,
    input wire [`CIFG_PPL_W-1:0] irq_prio_i,
    input wire nmi_i,
    input wire swi_exec_i,
    input wire [`CIFG_SWI_VEC_W-1:0] swi_vec_i,
    input wire flag_wr_i,
    input wire ien_wr_i,
    input wire ssel_wr_i,
    input wire [`CIFG_PPL_W-1:0] ppl_wr_i,
    input wire rsv_wr_i,
    input wire bank_sel_i,
    input wire reg_wr_i,
    input wire [`CIFG_IDX_W-1:0] reg_wr_idx_i,
    input wire [`CIFG_DATA_W-1:0] reg_wr_data_i,
    input wire [`CIFG_IDX_W-1:0] reg_rd_idx_i,
    output reg [`CIFG_DATA_W-1:0] reg_rd_data_o,
    output wire irq_ack_o,
    output wire nmi_ack_o,
    output wire irq_hold_o,
    output reg ien_o,
    output reg ssel_o,
    output wire isp_sel_o,
    output wire usp_sel_o,
    output reg [`CIFG_PPL_W-1:0] processor_priority_level_o,
    output wire rsv_rd_o
);

    // ============================================================
    // Declarations
    reg ien_q;
    reg ien_d;
    reg ssel_q;
    reg ssel_d;
    reg [`CIFG_PPL_W-1:0] ppl_q;
    reg [`CIFG_PPL_W-1:0] ppl_d;
    wire prio_ok;
    wire level_open;
    wire mask_ok;
    wire hw_ack;
    wire swi_low;
    wire ien_clr;
    wire ssel_clr;
    wire [1:0] bank_wr_en;
    wire [`CIFG_DATA_W-1:0] bank_rd [0:1];
    wire [`CIFG_DATA_W-1:0] rd_mux;

    // ============================================================
    // Decode helpers
    // Strictly greater: a request at the current level is refused
    function prio_above;
        input [`CIFG_PPL_W-1:0] req;
        input [`CIFG_PPL_W-1:0] lvl;
        begin
            prio_above = (req > lvl);
        end
    endfunction

    // Levels 0 and 1 leave maskable requests open, 2 to 7 shut them
    function level_allows;
        input [`CIFG_PPL_W-1:0] lvl;
        begin
            level_allows = (lvl < `CIFG_PPL_MASK_MIN);
        end
    endfunction

    // Software vectors 0 to 31 also move to the interrupt stack
    function swi_vec_low;
        input [`CIFG_SWI_VEC_W-1:0] vec;
        begin
            swi_vec_low = (vec <= `CIFG_SWI_VEC_MAX);
        end
    endfunction

    // ============================================================
    // Acceptance
    // RULE_06 strict priority compare
    assign prio_ok = prio_above(irq_prio_i, ppl_q);
    // RULE_07 high level masks all
    assign level_open = level_allows(ppl_q);
    // RULE_01 enable flag gate
    // RULE_10 both conditions needed
    assign mask_ok = ien_q && prio_ok && level_open;
    assign irq_ack_o = irq_pend_i && mask_ok;
    assign irq_hold_o = irq_pend_i && !mask_ok;

    // ============================================================
    // Acknowledge sources
    // Non-maskable requests are taken in the cycle they arrive
    assign nmi_ack_o = nmi_i;
    assign hw_ack = irq_ack_o || nmi_ack_o;
    assign swi_low = swi_exec_i && swi_vec_low(swi_vec_i);
    // RULE_02 ack clears enable
    assign ien_clr = hw_ack || swi_exec_i;
    // RULE_04 ack clears stack select
    assign ssel_clr = hw_ack || swi_low;

    // ============================================================
    // Enable flag next state
    // A clear from an acknowledge beats a flag write in the same cycle
    always @* begin
        ien_d = ien_q;
        if (ien_clr) begin
            ien_d = 1'b0;
        end else if (flag_wr_i) begin
            ien_d = ien_wr_i;
        end
    end

    // ============================================================
    // Stack select next state
    // Same precedence as the enable flag
    always @* begin
        ssel_d = ssel_q;
        if (ssel_clr) begin
            ssel_d = 1'b0;
        end else if (flag_wr_i) begin
            ssel_d = ssel_wr_i;
        end
    end

    // ============================================================
    // Priority level next state
    // RULE_05 three-bit level
    always @* begin
        ppl_d = ppl_q;
        if (flag_wr_i) begin
            ppl_d = ppl_wr_i;
        end
    end

    // ============================================================
    // Flag registers
    // RULE_11 update in ack cycle
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ien_q <= `CIFG_IEN_RST;
            ssel_q <= `CIFG_SSEL_RST;
            ppl_q <= `CIFG_PPL_RST;
        end else begin
            ien_q <= ien_d;
            ssel_q <= ssel_d;
            ppl_q <= ppl_d;
        end
    end

    // ============================================================
    // Flag outputs
    // Output copies always carry the same value as the internal flags
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ien_o <= `CIFG_IEN_RST;
            ssel_o <= `CIFG_SSEL_RST;
            processor_priority_level_o <= `CIFG_PPL_RST;
        end else begin
            ien_o <= ien_d;
            ssel_o <= ssel_d;
            processor_priority_level_o <= ppl_d;
        end
    end

    // ============================================================
    // Stack pointer select
    // RULE_03 stack pointer select
    assign isp_sel_o = !ssel_q;
    assign usp_sel_o = ssel_q;

    // ============================================================
    // Reserved bit
    // RULE_08 reserved bit reads fixed
    // The value on rsv_wr_i is dropped, so reads never depend on it
    assign rsv_rd_o = `CIFG_FLAG_RESERVED;

    // ============================================================
    // Register banks
    // RULE_09 two copies of the bank
    genvar b;
    generate
        for (b = 0; b < 2; b = b + 1) begin : g_bank
            assign bank_wr_en[b] = reg_wr_i && (bank_sel_i == b);
            cifg_bank u_bank (
                .core_clk_i(core_clk_i),
                .rstn_i(rstn_i),
                .wr_en_i(bank_wr_en[b]),
                .wr_idx_i(reg_wr_idx_i),
                .wr_data_i(reg_wr_data_i),
                .rd_idx_i(reg_rd_idx_i),
                .rd_data_o(bank_rd[b])
            );
        end
    endgenerate

    // ============================================================
    // Read data
    // Index 7 names no register and reads as zero inside each bank
    assign rd_mux = bank_sel_i ? bank_rd[1] : bank_rd[0];

    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            reg_rd_data_o <= 16'h0000;
        end else begin
            reg_rd_data_o <= rd_mux;
        end
    end
endmodule

// file: verification/cifg_irq_src.sv
// Request source that holds its line until acknowledged or dropped
`timescale 1ns/1ps
module cifg_irq_src (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic req_i,
    input wire logic drop_i,
    input wire logic ack_i,
    output logic pend_o
);
    always @(posedge core_clk_i) begin
        if (!rstn_i || ack_i || drop_i) begin
            pend_o <= 1'b0;
        end else if (req_i) begin
            pend_o <= 1'b1;
        end
    end
endmodule

// file: verification/cifg_top_properties.sv
// Checker for the interrupt gating ports
`timescale 1ns/1ps
module cifg_chk (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic irq_pend_i,
    input wire logic [2:0] irq_prio_i,
    input wire logic nmi_i,
    input wire logic swi_exec_i,
    input wire logic [5:0] swi_vec_i,
    input wire logic flag_wr_i,
    input wire logic [2:0] ppl_wr_i,
    input wire logic irq_ack_o,
    input wire logic nmi_ack_o,
    input wire logic irq_hold_o,
    input wire logic ien_o,
    input wire logic ssel_o,
    input wire logic isp_sel_o,
    input wire logic usp_sel_o,
    input wire logic [2:0] processor_priority_level_o,
    input wire logic rsv_rd_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    logic [2:0] lv;
    assign lv = processor_priority_level_o;
    a_ien_blocks: assert property (
        !ien_o |-> !irq_ack_o) else $error("ack while off");
    a_ack_ien_clr: assert property (
        irq_ack_o || nmi_ack_o |=> !ien_o) else $error("ien kept");
    a_sel_stack: assert property (
        isp_sel_o == !ssel_o && usp_sel_o == ssel_o) else $error("stack select");
    a_hw_ssel_clr: assert property (
        irq_ack_o || nmi_ack_o |=> !ssel_o) else $error("ssel kept");
    a_swi_clears: assert property (
        swi_exec_i && swi_vec_i <= 6'h1f |=> !ssel_o && !ien_o) else $error("swi clear");
    a_prio_strict: assert property (
        irq_prio_i <= lv |-> !irq_ack_o) else $error("prio");
    a_level_mask: assert property (
        lv >= 3'h2 |-> !irq_ack_o) else $error("mask");
    a_ack_taken: assert property (
        irq_pend_i && ien_o && irq_prio_i > lv && lv < 3'h2 |-> irq_ack_o)
        else $error("no ack");
    a_hold_pend: assert property (
        irq_pend_i && !irq_ack_o |-> irq_hold_o) else $error("hold");
    a_flag_load: assert property (
        flag_wr_i && !irq_ack_o && !nmi_i && !swi_exec_i |=> lv == $past(ppl_wr_i))
        else $error("ppl load");
    a_rsv_zero: assert property (
        rsv_rd_o == 1'b0) else $error("reserved bit");
    cover property (irq_ack_o);
    cover property (irq_hold_o && ien_o);
    cover property (swi_exec_i);
    cover property (nmi_ack_o);
endmodule
bind cifg_top cifg_chk cifg_chk_i (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .irq_pend_i(irq_pend_i),
    .irq_prio_i(irq_prio_i),
    .nmi_i(nmi_i),
    .swi_exec_i(swi_exec_i),
    .swi_vec_i(swi_vec_i),
    .flag_wr_i(flag_wr_i),
    .ppl_wr_i(ppl_wr_i),
    .irq_ack_o(irq_ack_o),
    .nmi_ack_o(nmi_ack_o),
    .irq_hold_o(irq_hold_o),
    .ien_o(ien_o),
    .ssel_o(ssel_o),
    .isp_sel_o(isp_sel_o),
    .usp_sel_o(usp_sel_o),
    .processor_priority_level_o(processor_priority_level_o),
    .rsv_rd_o(rsv_rd_o)
);

// file: verification/testbench.sv
// Self-checking bench for the interrupt gating block
`timescale 1ns/1ps
module testbench;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic req, drop, pend, nmi, swx, fw, ienw, sselw, bsel, rwr, ack, hold, ien, ssel, rsv;
    logic nack, interrupt_stack_pointer, user_stack_pointer;
    logic [2:0] prio, pplw, widx, ridx, ppl;
    logic [5:0] vec;
    logic [15:0] wdat, rdat;
    int n_mismatch = 0;
    int total_checks = 0;
    always #5 core_clk_i = ~core_clk_i;
    cifg_irq_src cifg_irq_src_i (.core_clk_i, .rstn_i, .req_i(req), .drop_i(drop), .ack_i(ack),
        .pend_o(pend));
    cifg_top cifg_top_i (.core_clk_i, .rstn_i, .irq_pend_i(pend), .irq_prio_i(prio),
        .nmi_i(nmi), .swi_exec_i(swx), .swi_vec_i(vec), .flag_wr_i(fw), .ien_wr_i(ienw),
        .ssel_wr_i(sselw), .ppl_wr_i(pplw), .rsv_wr_i(1'b0), .bank_sel_i(bsel), .reg_wr_i(rwr),
        .reg_wr_idx_i(widx), .reg_wr_data_i(wdat), .reg_rd_idx_i(ridx), .reg_rd_data_o(rdat),
        .irq_ack_o(ack), .nmi_ack_o(nack), .irq_hold_o(hold), .ien_o(ien), .ssel_o(ssel),
        .isp_sel_o(interrupt_stack_pointer), .usp_sel_o(user_stack_pointer), .processor_priority_level_o(ppl), .rsv_rd_o(rsv));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task flags(input logic [2:0] p);
        @(negedge core_clk_i) {fw, ienw, sselw, pplw} = {3'b111, p};
        @(negedge core_clk_i) fw = 1'b0;
    endtask
    task t_gate();
        logic e;
        for (int i = 0; i < 24; i++) begin
            e = (i % 8 > i / 8) && (i / 8 < 2);
            flags(3'(i / 8));
            {req, prio} = {1'b1, 3'(i % 8)};
            @(negedge core_clk_i) req = 1'b0;
            chk(ack, e);
            chk(hold, !e);
            @(negedge core_clk_i) drop = 1'b1;
            chk({ien, ssel}, {2{!e}});
            @(negedge core_clk_i) drop = 1'b0;
        end
    endtask
    task t_clear(input logic is_nmi, input logic [5:0] v);
        logic keep;
        keep = !is_nmi && v > 6'h1f;
        flags(3'h0);
        {nmi, swx, vec} = {is_nmi, !is_nmi, v};
        #1 chk(nack, is_nmi);
        @(negedge core_clk_i) {nmi, swx} = 2'b00;
        chk({ien, ssel}, {1'b0, keep});
        chk({interrupt_stack_pointer, user_stack_pointer}, {!keep, keep});
    endtask
    task t_regs();
        for (int b = 0; b < 2; b++) begin
            @(negedge core_clk_i) {rwr, bsel, widx} = {1'b1, 1'(b), 3'h6};
            wdat = 16'ha5a0 + 16'(b);
        end
        @(negedge core_clk_i) rwr = 1'b0;
        for (int b = 0; b < 3; b++) begin
            {bsel, ridx} = {1'(b), b == 2 ? 3'h7 : 3'h6};
            @(negedge core_clk_i) chk(rdat, b == 2 ? 16'h0 : 16'ha5a0 + 16'(b));
        end
    endtask
    task end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        {req, drop, nmi, swx, fw, ienw, sselw, bsel, rwr, prio, pplw, widx, ridx, vec, wdat} = '0;
        repeat (10) @(negedge core_clk_i);
        rstn_i = 1'b1;
        chk({ien, ssel, ppl, rsv}, 6'h0);
        t_gate();
        t_clear(1'b1, 6'h00);
        foreach (vec[k]) t_clear(1'b0, 6'h1f + 6'(k % 2));
        flags(3'h7);
        chk(ppl, 3'h7);
        @(negedge core_clk_i) rstn_i = 1'b0;
        @(negedge core_clk_i) rstn_i = 1'b1;
        chk({ien, ssel, ppl}, 5'h0);
        t_regs();
        end_of_test();
    end
    initial begin
        #100us;
        n_mismatch++;
        end_of_test();
    end
endmodule
